//--- include/adcc_pkg.sv
/*
 * Package for the converter control block: register offsets, field
 * positions, widths, reset values and the sequencer states.
 * Assumes a 32-bit AHB-Lite register bus decoding the low address byte.
 */
package adcc_pkg;
    // Register byte offsets
    localparam logic [7:0] ADCC_OFS_MAIN    = 8'h00; // main_control_reg
    localparam logic [7:0] ADCC_OFS_CLK     = 8'h04; // clock_config_reg
    localparam logic [7:0] ADCC_OFS_REF     = 8'h08; // reference_select_reg
    localparam logic [7:0] ADCC_OFS_EVT     = 8'h0c; // event_config_reg
    localparam logic [7:0] ADCC_OFS_TRIM    = 8'h10; // trim_values_reg
    localparam logic [7:0] ADCC_OFS_DBG     = 8'h14; // debug_behaviour_reg
    localparam logic [7:0] ADCC_OFS_TRIG    = 8'h18; // software_trigger_reg
    localparam logic [7:0] ADCC_OFS_INPUT   = 8'h1c; // input_select_reg
    localparam logic [7:0] ADCC_OFS_IEN_SET = 8'h20; // irq_enable_set_reg
    localparam logic [7:0] ADCC_OFS_IEN_CLR = 8'h24; // irq enable clear
    localparam logic [7:0] ADCC_OFS_FLAG    = 8'h28; // irq_flag_reg
    localparam logic [7:0] ADCC_OFS_RESULT  = 8'h2c; // result register

    // Field positions
    localparam int ADCC_MAIN_EN_BIT   = 0;
    localparam int ADCC_MAIN_SRST_BIT = 1;
    localparam int ADCC_CLK_FREE_BIT  = 3;
    localparam int ADCC_EVT_START_BIT = 0;
    localparam int ADCC_TRIG_STRT_BIT = 1;
    localparam int ADCC_FLAG_RDY_BIT  = 0;
    localparam int ADCC_FLAG_OVR_BIT  = 1;

    // Field widths
    localparam int ADCC_RES_W   = 12;
    localparam int ADCC_MUX_W   = 5;
    localparam int ADCC_REF_W   = 4;
    localparam int ADCC_TRIM_W  = 12;
    localparam int ADCC_PRESC_W = 3;
    localparam int ADCC_FLAG_W  = 2;
    localparam int ADCC_DIV_W   = 8;

    // Values after reset
    localparam logic [ADCC_PRESC_W-1:0] ADCC_RST_PRESC = 3'h0;
    localparam logic [ADCC_REF_W-1:0]   ADCC_RST_REF   = 4'h0;
    localparam logic [ADCC_TRIM_W-1:0]  ADCC_RST_TRIM  = 12'h000;
    localparam logic [ADCC_MUX_W-1:0]   ADCC_RST_MUX   = 5'h00;
    localparam logic [ADCC_RES_W-1:0]   ADCC_RST_RES   = 12'h000;
    localparam logic [ADCC_FLAG_W-1:0]  ADCC_RST_FLAG  = 2'h0;
    localparam logic [ADCC_DIV_W-1:0]   ADCC_RST_DIV   = 8'h00;

    // Conversion sequencer states
    typedef enum logic [1:0] {
        ADCC_ST_IDLE = 2'b01,
        ADCC_ST_BUSY = 2'b10
    } adcc_state_t;
endpackage

//--- src/adcc_ctrl.sv
/*
 * Converter control block: AHB-Lite register file, enable protection,
 * soft reset, trigger sequencing, result capture, flags and interrupt.
 * Assumes the analog core pulses CONV_DONE with CONV_DATA valid, only
 * after a CONV_START, and that TRIG_EVT is a one-cycle event pulse.
 */
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

// Notes on behaviour
// - The clock, reference, event and trim registers take writes only while disabled.
// - Writing one to the enable bit turns the converter on.
// - Writing zero to the enable bit turns the converter off.
// - Writing one to the soft reset bit clears all registers but debug and disables.
// - Writing one to the start bit of the trigger register starts a conversion.
// - With the event start enabled, each trigger event arriving while enabled and idle starts a conversion.
// - In free-running mode software starts the first conversion and each end restarts.
// - Each completed conversion overwrites the single result register.
// - The result-ready flag rises when a new result is in the result register.
// - A new result arriving while the result-ready flag is still set sets the overrun flag, unless that cycle reads the flag or result register.
// - Writing one to an interrupt enable set bit enables that interrupt source.
// - The converter tick comes from the clock divided by two to the power of the programmed prescaler plus one.
// - The core samples the input chosen by the input select register.
module adcc_ctrl
(
    // Clock and reset
    input  wire logic                             CLK,
    input  wire logic                             RST_N,
    // AHB-Lite slave
    input  wire logic                             HSEL,
    input  wire logic [31:0]                      HADDR,
    input  wire logic [1:0]                       HTRANS,
    input  wire logic                             HWRITE,
    input  wire logic [2:0]                       HSIZE,
    input  wire logic [31:0]                      HWDATA,
    input  wire logic                             HREADY,
    output logic      [31:0]                      HRDATA,
    output logic                                  HREADYOUT,
    output logic                                  HRESP,
    // Analog core
    output logic                                  CONV_ENABLE,
    output logic                                  CONV_START,
    output logic                                  CONV_TICK,
    output logic      [adcc_pkg::ADCC_MUX_W-1:0]  CONV_MUX,
    output logic      [adcc_pkg::ADCC_REF_W-1:0]  CONV_REF,
    output logic      [adcc_pkg::ADCC_TRIM_W-1:0] CONV_TRIM,
    input  wire logic                             CONV_DONE,
    input  wire logic [adcc_pkg::ADCC_RES_W-1:0]  CONV_DATA,
    // Trigger event, debug, interrupt
    input  wire logic                             TRIG_EVT,
    output logic                                  DBG_RUN,
    output logic                                  IRQ
);
    import adcc_pkg::*;

    // True for the enable-protected registers
    function automatic logic adcc_is_prot(input logic [7:0] ofs);
        adcc_is_prot = (ofs == ADCC_OFS_CLK) || (ofs == ADCC_OFS_REF) ||
                       (ofs == ADCC_OFS_EVT) || (ofs == ADCC_OFS_TRIM);
    endfunction

    logic [7:0]               addr_ff,  nxt_addr;
    logic                     wr_ff,    nxt_wr;
    logic                     rd_ff,    nxt_rd;
    logic [31:0]              rdata_ff, nxt_rdata;
    logic                     en_ff,    nxt_en;
    logic                     srst_ff,  nxt_srst;
    logic [ADCC_PRESC_W-1:0]  presc_ff, nxt_presc;
    logic                     free_ff,  nxt_free;
    logic [ADCC_REF_W-1:0]    ref_ff,   nxt_ref;
    logic                     evten_ff, nxt_evten;
    logic [ADCC_TRIM_W-1:0]   trim_ff,  nxt_trim;
    logic                     dbg_ff,   nxt_dbg;
    logic [ADCC_MUX_W-1:0]    mux_ff,   nxt_mux;
    logic [ADCC_FLAG_W-1:0]   ien_ff,   nxt_ien;
    logic [ADCC_FLAG_W-1:0]   flag_ff,  nxt_flag;
    logic [ADCC_RES_W-1:0]    res_ff,   nxt_res;
    adcc_state_t              st_ff,    nxt_st;
    logic                     start_ff, nxt_start;
    logic [ADCC_DIV_W-1:0]    div_ff,   nxt_div;
    logic                     tick_ff,  nxt_tick;
    logic                     take, wr_hit_ok, done_hit, fire;
    logic                     rd_flag, rd_res;
    logic [ADCC_DIV_W:0]      div_lim;

    // Bus phase tracking; reads get one wait state so that read data comes
    // from a flop yet already sees a write completed on the previous edge
    always_comb
    begin
        take      = HSEL && HREADY && HTRANS[1];
        nxt_addr  = take ? HADDR[7:0] : addr_ff;
        nxt_wr    = take && HWRITE;
        nxt_rd    = take && !HWRITE;
        nxt_rdata = rdata_ff;
        if (rd_ff)
        begin
            unique case (addr_ff)
                ADCC_OFS_MAIN:    nxt_rdata = {30'h0, 1'b0, en_ff};
                ADCC_OFS_CLK:     nxt_rdata = {28'h0, free_ff, presc_ff};
                ADCC_OFS_REF:     nxt_rdata = {28'h0, ref_ff};
                ADCC_OFS_EVT:     nxt_rdata = {31'h0, evten_ff};
                ADCC_OFS_TRIM:    nxt_rdata = {20'h0, trim_ff};
                ADCC_OFS_DBG:     nxt_rdata = {31'h0, dbg_ff};
                ADCC_OFS_INPUT:   nxt_rdata = {27'h0, mux_ff};
                ADCC_OFS_IEN_SET, ADCC_OFS_IEN_CLR: nxt_rdata = {30'h0, ien_ff};
                ADCC_OFS_FLAG:    nxt_rdata = {30'h0, flag_ff};
                ADCC_OFS_RESULT:  nxt_rdata = {20'h0, res_ff};
                default:          nxt_rdata = 32'h0; // Unmapped and trigger read zero
            endcase
        end
    end
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            addr_ff  <= 8'h00;
            wr_ff    <= 1'b0;
            rd_ff    <= 1'b0;
            rdata_ff <= 32'h0;
        end
        else
        begin
            addr_ff  <= nxt_addr;
            wr_ff    <= nxt_wr;
            rd_ff    <= nxt_rd;
            rdata_ff <= nxt_rdata;
        end
    end
    assign HRDATA    = rdata_ff;
    assign HREADYOUT = !rd_ff;
    assign HRESP     = 1'b0; // Always OKAY

    // Conversion start and read side effects
    always_comb
    begin
        wr_hit_ok = wr_ff && !srst_ff && !(adcc_is_prot(addr_ff) && en_ff);
        done_hit  = (st_ff == ADCC_ST_BUSY) && CONV_DONE && en_ff;
        rd_flag   = rd_ff && (addr_ff == ADCC_OFS_FLAG);
        rd_res    = rd_ff && (addr_ff == ADCC_OFS_RESULT);
        fire      = 1'b0;
        if (en_ff && !srst_ff)
        begin
            if ((st_ff == ADCC_ST_IDLE) && wr_hit_ok && (addr_ff == ADCC_OFS_TRIG) &&
                HWDATA[ADCC_TRIG_STRT_BIT])
                fire = 1'b1;
            if ((st_ff == ADCC_ST_IDLE) && evten_ff && TRIG_EVT)
                fire = 1'b1;
            if (done_hit && free_ff)
                fire = 1'b1;
        end
    end

    // Register file next values; soft reset spares only the debug register
    always_comb
    begin
        nxt_srst  = 1'b0;
        nxt_en    = en_ff;
        nxt_presc = presc_ff;
        nxt_free  = free_ff;
        nxt_ref   = ref_ff;
        nxt_evten = evten_ff;
        nxt_trim  = trim_ff;
        nxt_dbg   = dbg_ff;
        nxt_mux   = mux_ff;
        nxt_ien   = ien_ff;
        nxt_flag  = flag_ff;
        nxt_res   = res_ff;
        if (srst_ff)
        begin
            nxt_en    = 1'b0;
            nxt_presc = ADCC_RST_PRESC;
            nxt_free  = 1'b0;
            nxt_ref   = ADCC_RST_REF;
            nxt_evten = 1'b0;
            nxt_trim  = ADCC_RST_TRIM;
            nxt_mux   = ADCC_RST_MUX;
            nxt_ien   = ADCC_RST_FLAG;
            nxt_flag  = ADCC_RST_FLAG;
            nxt_res   = ADCC_RST_RES;
        end
        else
        begin
            if (wr_hit_ok)
            begin
                unique case (addr_ff)
                    ADCC_OFS_MAIN:
                    begin
                        nxt_en   = HWDATA[ADCC_MAIN_EN_BIT];
                        nxt_srst = HWDATA[ADCC_MAIN_SRST_BIT];
                    end
                    ADCC_OFS_CLK:
                    begin
                        nxt_presc = HWDATA[ADCC_PRESC_W-1:0];
                        nxt_free  = HWDATA[ADCC_CLK_FREE_BIT];
                    end
                    ADCC_OFS_REF:     nxt_ref   = HWDATA[ADCC_REF_W-1:0];
                    ADCC_OFS_EVT:     nxt_evten = HWDATA[ADCC_EVT_START_BIT];
                    ADCC_OFS_TRIM:    nxt_trim  = HWDATA[ADCC_TRIM_W-1:0];
                    ADCC_OFS_DBG:     nxt_dbg   = HWDATA[0];
                    ADCC_OFS_INPUT:   nxt_mux   = HWDATA[ADCC_MUX_W-1:0];
                    ADCC_OFS_IEN_SET: nxt_ien   = ien_ff | HWDATA[ADCC_FLAG_W-1:0];
                    ADCC_OFS_IEN_CLR: nxt_ien   = ien_ff & ~HWDATA[ADCC_FLAG_W-1:0];
                    default:          nxt_ien   = ien_ff; // Others hold
                endcase
            end
            // Reads clear flags; a result landing in the same cycle still sets ready but raises no overrun
            if (rd_flag || rd_res)
                nxt_flag[ADCC_FLAG_RDY_BIT] = 1'b0;
            if (rd_flag)
                nxt_flag[ADCC_FLAG_OVR_BIT] = 1'b0;
            if (done_hit)
            begin
                nxt_res = CONV_DATA;
                nxt_flag[ADCC_FLAG_RDY_BIT] = 1'b1;
                if (flag_ff[ADCC_FLAG_RDY_BIT] && !rd_res && !rd_flag)
                    nxt_flag[ADCC_FLAG_OVR_BIT] = 1'b1;
            end
        end
    end
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            srst_ff  <= 1'b0;
            en_ff    <= 1'b0;
            presc_ff <= ADCC_RST_PRESC;
            free_ff  <= 1'b0;
            ref_ff   <= ADCC_RST_REF;
            evten_ff <= 1'b0;
            trim_ff  <= ADCC_RST_TRIM;
            dbg_ff   <= 1'b0;
            mux_ff   <= ADCC_RST_MUX;
            ien_ff   <= ADCC_RST_FLAG;
            flag_ff  <= ADCC_RST_FLAG;
            res_ff   <= ADCC_RST_RES;
        end
        else
        begin
            srst_ff  <= nxt_srst;
            en_ff    <= nxt_en;
            presc_ff <= nxt_presc;
            free_ff  <= nxt_free;
            ref_ff   <= nxt_ref;
            evten_ff <= nxt_evten;
            trim_ff  <= nxt_trim;
            dbg_ff   <= nxt_dbg;
            mux_ff   <= nxt_mux;
            ien_ff   <= nxt_ien;
            flag_ff  <= nxt_flag;
            res_ff   <= nxt_res;
        end
    end
    // Sequencer and prescaler; a disable aborts a conversion in flight
    always_comb
    begin
        nxt_start = fire;
        nxt_st    = st_ff;
        unique case (st_ff)
            ADCC_ST_IDLE: if (fire) nxt_st = ADCC_ST_BUSY;
            ADCC_ST_BUSY: if (done_hit && !fire) nxt_st = ADCC_ST_IDLE;
            default:      nxt_st = ADCC_ST_IDLE;
        endcase
        if (!en_ff || srst_ff)
            nxt_st = ADCC_ST_IDLE;
        div_lim  = (9'h002 << presc_ff) - 9'h001;
        nxt_tick = 1'b0;
        nxt_div  = ADCC_RST_DIV;
        if (en_ff)
        begin
            nxt_tick = (div_ff == div_lim[ADCC_DIV_W-1:0]);
            nxt_div  = nxt_tick ? ADCC_RST_DIV : div_ff + 8'h01;
        end
    end
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            st_ff    <= ADCC_ST_IDLE;
            start_ff <= 1'b0;
            div_ff   <= ADCC_RST_DIV;
            tick_ff  <= 1'b0;
        end
        else
        begin
            st_ff    <= nxt_st;
            start_ff <= nxt_start;
            div_ff   <= nxt_div;
            tick_ff  <= nxt_tick;
        end
    end
    // Core-facing outputs, then the debug run and interrupt outputs
    assign CONV_ENABLE = en_ff;
    assign CONV_START  = start_ff;
    assign CONV_TICK   = tick_ff;
    assign CONV_MUX    = mux_ff;
    assign CONV_REF    = ref_ff;
    assign CONV_TRIM   = trim_ff;
    assign DBG_RUN     = dbg_ff;
    assign IRQ         = |(flag_ff & ien_ff);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    prot_write_drop_a: assert property (wr_ff && en_ff && (addr_ff == ADCC_OFS_REF)
        |=> $stable(ref_ff)) else $error("protected write changed reference");
    prot_trim_drop_a: assert property (wr_ff && en_ff && (addr_ff == ADCC_OFS_TRIM)
        |=> $stable(trim_ff)) else $error("protected write changed trim");
    enable_write_a: assert property (wr_ff && !srst_ff && (addr_ff == ADCC_OFS_MAIN)
        |=> (CONV_ENABLE == $past(HWDATA[0]))) else $error("enable did not follow write");
    disable_abort_a: assert property (!en_ff |=> (st_ff == ADCC_ST_IDLE))
        else $error("sequencer busy while disabled");
    soft_reset_a: assert property (srst_ff |=> !en_ff && (flag_ff == 2'h0) &&
        (mux_ff == 5'h00) && (dbg_ff == $past(dbg_ff))) else $error("soft reset incomplete");
    sw_start_a: assert property (en_ff && !srst_ff && (st_ff == ADCC_ST_IDLE) && wr_ff &&
        (addr_ff == ADCC_OFS_TRIG) && HWDATA[1] |=> CONV_START) else $error("no start");
    evt_start_a: assert property (en_ff && !srst_ff && evten_ff &&
        (st_ff == ADCC_ST_IDLE) && TRIG_EVT |=> CONV_START ##1 !CONV_START)
        else $error("event did not start one conversion");
    free_restart_a: assert property (done_hit && free_ff && !srst_ff
        |=> CONV_START && (st_ff == ADCC_ST_BUSY)) else $error("free run did not restart");
    result_load_a: assert property (done_hit && !srst_ff |=>
        (res_ff == $past(CONV_DATA)) && flag_ff[0]) else $error("result not stored");
    overrun_set_a: assert property (done_hit && !srst_ff && flag_ff[0] && !rd_ff
        |=> flag_ff[1]) else $error("overrun missed");
    ien_set_a: assert property (wr_ff && !srst_ff && (addr_ff == ADCC_OFS_IEN_SET)
        |=> ((ien_ff & $past(HWDATA[1:0])) == $past(HWDATA[1:0])))
        else $error("enable set lost");
    tick_div2_a: assert property (en_ff && (presc_ff == 3'h0) && tick_ff &&
        $stable(presc_ff) |=> !tick_ff ##1 (tick_ff || !$past(en_ff)))
        else $error("prescaler period wrong");
    irq_level_a: assert property (IRQ == ((flag_ff[0] && ien_ff[0]) ||
        (flag_ff[1] && ien_ff[1]))) else $error("interrupt level wrong");

    sw_conv_c: cover property (CONV_START ##[1:50] done_hit);
    overrun_c: cover property (done_hit && flag_ff[0] ##1 flag_ff[1]);
    free_run_c: cover property (free_ff && done_hit ##1 CONV_START);
    irq_c: cover property (!IRQ ##1 IRQ);
endmodule

//--- test/adcc_core_model.sv
/* Behavioural analog core: counts converter ticks after each start and
   returns a result made of the selected input and a sequence count.
   Assumes one-cycle start and tick pulses from the control block. */
`timescale 1ns/1ps
module adcc_core_model
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Control side
    input  wire logic        enable,
    input  wire logic        start,
    input  wire logic        tick,
    input  wire logic [4:0]  mux,
    input  wire logic        slow,
    // Result side
    output logic             done,
    output logic [11:0]      data
);
    logic        busy;
    logic [3:0]  ticks;
    logic [6:0]  seq;
    logic [11:0] last;

    // Conversion lasts two ticks, or eight with slow set; a disable aborts it
    always @(posedge clk)
    begin
        done <= 1'b0;
        if (!rst_n)
        begin
            busy <= 1'b0;
            seq  <= 7'h00;
            last <= 12'h000;
        end
        else if (!enable)
            busy <= 1'b0;
        else if (start)
        begin
            busy  <= 1'b1;
            ticks <= 4'h0;
        end
        else if (busy && tick)
        begin
            ticks <= ticks + 4'h1;
            if (ticks == (slow ? 4'h7 : 4'h1))
            begin
                busy <= 1'b0;
                done <= 1'b1;
                last <= {mux, seq};
                seq  <= seq + 7'h01;
            end
        end
    end

    // Outside the done cycle the line shows the inverse of the last value
    assign data = done ? last : ~last;
endmodule

//--- test/adcc_ctrl_tb.sv
/* Self-checking bench for the converter control block: register table,
   protection, soft reset, triggers, flags, interrupt and prescaler.
   Assumes the behavioural core model stands on the analog side. */
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        n_compared++; \
        if ((g) !== (e)) \
        begin \
            err_total++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
        end \
    end
module adcc_ctrl_tb;
    import adcc_pkg::*;
    localparam int NR = 12;
    localparam logic [7:0] r_adr [NR] = '{ADCC_OFS_CLK, ADCC_OFS_REF, ADCC_OFS_EVT,
        ADCC_OFS_TRIM, ADCC_OFS_DBG, ADCC_OFS_INPUT, ADCC_OFS_TRIG, ADCC_OFS_IEN_CLR,
        ADCC_OFS_IEN_SET, ADCC_OFS_FLAG, ADCC_OFS_RESULT, 8'h30};
    localparam logic [31:0] r_exp [NR] = '{32'hf, 32'hf, 32'h1, 32'hfff, 32'h1, 32'h1f,
        32'h0, 32'h0, 32'h3, 32'h0, 32'h0, 32'h0};
    logic                   CLK;
    logic                   RST_N;
    logic                   HSEL;
    logic [31:0]            HADDR;
    logic [1:0]             HTRANS;
    logic                   HWRITE;
    logic [31:0]            HWDATA;
    logic                   TRIG_EVT;
    logic                   slow;
    logic [31:0]            HRDATA;
    logic                   HREADYOUT;
    logic                   HRESP;
    logic                   CONV_ENABLE;
    logic                   CONV_START;
    logic                   CONV_TICK;
    logic [ADCC_MUX_W-1:0]  CONV_MUX;
    logic [ADCC_REF_W-1:0]  CONV_REF;
    logic [ADCC_TRIM_W-1:0] CONV_TRIM;
    logic                   CONV_DONE;
    logic [ADCC_RES_W-1:0]  CONV_DATA;
    logic                   DBG_RUN;
    logic                   IRQ;
    logic [31:0]            rdv;
    int                     err_total;
    int                     n_compared;
    int                     n_start;
    int                     n_done;
    int                     cyc;
    int                     per;
    int                     s0;

    // Word transfers only, so the size is tied; the slave's ready is the bus ready
    adcc_ctrl DUT (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CONV_ENABLE(CONV_ENABLE),
        .CONV_START(CONV_START), .CONV_TICK(CONV_TICK), .CONV_MUX(CONV_MUX),
        .CONV_REF(CONV_REF), .CONV_TRIM(CONV_TRIM), .CONV_DONE(CONV_DONE),
        .CONV_DATA(CONV_DATA), .TRIG_EVT(TRIG_EVT), .DBG_RUN(DBG_RUN), .IRQ(IRQ));
    adcc_core_model core (.clk(CLK), .rst_n(RST_N), .enable(CONV_ENABLE), .start(CONV_START),
        .tick(CONV_TICK), .mux(CONV_MUX), .slow(slow), .done(CONV_DONE), .data(CONV_DATA));

    // Free-running clock
    always #5 CLK = ~CLK;

    // Event counters and the hang limit
    always @(posedge CLK)
    begin
        n_start += (CONV_START === 1'b1);
        n_done  += (CONV_DONE === 1'b1);
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            final_report();
        end
    end

    task automatic final_report;
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One single transfer; ready and read data are sampled the half cycle before the edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic rdy;
        @(posedge CLK);
        HSEL   <= 1'b1;
        HTRANS <= 2'b10;
        HWRITE <= w;
        HADDR  <= {24'h000000, a};
        do
        begin
            @(negedge CLK);
            rdy = HREADYOUT;
            @(posedge CLK);
        end
        while (rdy !== 1'b1);
        HTRANS <= 2'b00;
        HWDATA <= d;
        do
        begin
            @(negedge CLK);
            rdy = HREADYOUT;
            rdv = HRDATA;
            @(posedge CLK);
        end
        while (rdy !== 1'b1);
        HSEL <= 1'b0;
        @(negedge CLK);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h00000000);
        `CHK(rdv, e)
    endtask

    // Bounded wait for a finished conversion, then past the edge that stores it
    task automatic wait_done;
        int k;
        k = 0;
        do
        begin
            @(negedge CLK);
            k++;
        end
        while (CONV_DONE !== 1'b1 && k < 500);
        @(negedge CLK);
    endtask

    task automatic pulse_evt;
        @(posedge CLK);
        TRIG_EVT <= 1'b1;
        @(posedge CLK);
        TRIG_EVT <= 1'b0;
        @(negedge CLK);
    endtask

    // Cycles between two converter ticks
    task automatic meas;
        int k;
        k = 0;
        while (CONV_TICK !== 1'b1 && k < 600)
        begin
            @(negedge CLK);
            k++;
        end
        per = 0;
        do
        begin
            @(negedge CLK);
            per++;
        end
        while (CONV_TICK !== 1'b1 && per < 600);
    endtask

    // Result expected from the core model: input select and conversion count
    function automatic logic [31:0] exp_res(input logic [4:0] m);
        return {20'h00000, m, 7'(n_done - 1)};
    endfunction

    // Main sequence
    initial
    begin
        CLK = 0;
        RST_N = 0;
        HSEL = 0;
        HADDR = 0;
        HTRANS = 0;
        HWRITE = 0;
        HWDATA = 0;
        TRIG_EVT = 0;
        slow = 0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        @(negedge CLK);
        for (int i = 0; i < NR; i++)
        begin
            rchk(r_adr[i], 32'h0);
            xfer(1'b1, r_adr[i], 32'hffffffff);
            rchk(r_adr[i], r_exp[i]);
        end
        `CHK(HRESP, 1'b0)
        $display("test register table done");
        xfer(1'b1, ADCC_OFS_MAIN, 32'h1);
        xfer(1'b1, ADCC_OFS_MAIN, 32'h3);
        repeat (3) @(negedge CLK);
        rchk(ADCC_OFS_TRIM, 32'h0);
        rchk(ADCC_OFS_IEN_SET, 32'h0);
        rchk(ADCC_OFS_DBG, 32'h1);
        `CHK(CONV_ENABLE, 1'b0)
        `CHK(DBG_RUN, 1'b1)
        $display("test soft reset done");
        xfer(1'b1, ADCC_OFS_TRIM, 32'h123);
        xfer(1'b1, ADCC_OFS_INPUT, 32'h5);
        xfer(1'b1, ADCC_OFS_REF, 32'h9);
        xfer(1'b1, ADCC_OFS_MAIN, 32'h1);
        `CHK(CONV_ENABLE, 1'b1)
        xfer(1'b1, ADCC_OFS_TRIM, 32'h456);
        xfer(1'b1, ADCC_OFS_EVT, 32'h1);
        rchk(ADCC_OFS_TRIM, 32'h123);
        rchk(ADCC_OFS_EVT, 32'h0);
        xfer(1'b1, ADCC_OFS_REF, 32'h3);
        `CHK(CONV_TRIM, 12'h123)
        `CHK(CONV_REF, 4'h9)
        `CHK(CONV_MUX, 5'h05)
        $display("test protection done");
        xfer(1'b1, ADCC_OFS_IEN_SET, 32'h1);
        xfer(1'b1, ADCC_OFS_TRIG, 32'h2);
        wait_done();
        `CHK(IRQ, 1'b1)
        xfer(1'b1, ADCC_OFS_IEN_CLR, 32'h1);
        `CHK(IRQ, 1'b0)
        xfer(1'b1, ADCC_OFS_IEN_SET, 32'h1);
        `CHK(IRQ, 1'b1)
        rchk(ADCC_OFS_RESULT, exp_res(5'h05));
        `CHK(IRQ, 1'b0)
        $display("test software trigger done");
        slow = 1'b1;
        xfer(1'b1, ADCC_OFS_TRIG, 32'h2);
        wait_done();
        xfer(1'b1, ADCC_OFS_TRIG, 32'h2);
        wait_done();
        rchk(ADCC_OFS_FLAG, 32'h3);
        rchk(ADCC_OFS_RESULT, exp_res(5'h05));
        rchk(ADCC_OFS_FLAG, 32'h0);
        $display("test overrun done");
        slow = 1'b0;
        xfer(1'b1, ADCC_OFS_MAIN, 32'h0);
        `CHK(CONV_ENABLE, 1'b0)
        xfer(1'b1, ADCC_OFS_EVT, 32'h1);
        s0 = n_start;
        pulse_evt();
        repeat (2) @(negedge CLK);
        `CHK(n_start, s0)
        xfer(1'b1, ADCC_OFS_MAIN, 32'h1);
        pulse_evt();
        wait_done();
        rchk(ADCC_OFS_RESULT, exp_res(5'h05));
        $display("test event trigger done");
        xfer(1'b1, ADCC_OFS_MAIN, 32'h0);
        xfer(1'b1, ADCC_OFS_CLK, 32'h8);
        xfer(1'b1, ADCC_OFS_EVT, 32'h0);
        xfer(1'b1, ADCC_OFS_MAIN, 32'h1);
        s0 = n_start;
        xfer(1'b1, ADCC_OFS_TRIG, 32'h2);
        repeat (3) wait_done();
        `CHK(n_start - s0, 3)
        $display("test free running done");
        for (int p = 0; p < 8; p += 3)
        begin
            xfer(1'b1, ADCC_OFS_MAIN, 32'h0);
            xfer(1'b1, ADCC_OFS_CLK, 32'(p));
            xfer(1'b1, ADCC_OFS_MAIN, 32'h1);
            meas();
            `CHK(per, 1 << (p + 1))
        end
        $display("test prescaler done");
        @(posedge CLK);
        RST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        @(negedge CLK);
        `CHK(CONV_ENABLE, 1'b0)
        `CHK(DBG_RUN, 1'b0)
        rchk(ADCC_OFS_CLK, 32'h0);
        $display("test mid-run reset done");
        final_report();
    end
endmodule
